/* File: hdl/gcp_pins.sv */
// five general pins with coexistence function selection
// assumes pad cells resolve pin level from out/oe and apply pulls
`timescale 1ns/1ps
module gcp_pins
   import gcp_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic [4:0] pinDir,
   input wire logic [4:0] pinWrite,
   input wire logic [4:0] pullEn,
   input wire logic [4:0] pullSelUp,
   input wire logic wakeSel,
   input wire gcp_mode_t coexMode,
   input wire logic radioHostWakeupOut,
   input wire logic coexSerialOut,
   input wire logic [3:0] prioSrc,
   input wire logic [3:0] prioMask,
   input wire logic [4:0] gpioI,
   output logic [4:0] gpioO,
   output logic [4:0] gpioOe,
   output logic [4:0] pullUpEn,
   output logic [4:0] pullDownEn,
   output logic [4:0] pinRead,
   output logic coexSerialIn,
   output logic peerReceiveActive,
   output logic peerTransmitActive,
   output logic peerFrameSync,
   output logic priorityOut
);

   gcp_state_t state_r; // registered block state
   gcp_state_t state_nxt; // next block state
   logic [4:0] syncIn; // pin levels after two flops
   logic prioAny; // masked priority combination

   // pad input synchroniser
   gcp_sync #(
      .WIDTH(GCP_NUM_PINS)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .asyncIn(gpioI),
      .syncOut(syncIn)
   );

   // masked OR of internal priority sources
   assign prioAny = |(prioSrc & prioMask);

   // pin function and drive selection
   always_comb begin
      state_nxt = state_r;
      // ordinary direction, level and pull per pin
      state_nxt.pinOe = pinDir;
      state_nxt.pinOut = pinWrite;
      state_nxt.pullUpEn = pullEn & pullSelUp;
      state_nxt.pullDownEn = pullEn & ~pullSelUp;
      state_nxt.prio = prioAny;
      // idle answers of the peer-facing signals
      state_nxt.serialIn = GCP_SERIAL_IDLE;
      state_nxt.rxAct = 1'h0;
      state_nxt.txAct = 1'h0;
      state_nxt.frameSync = 1'h0;
      // pin zero as wakeup output
      if (wakeSel) begin
         state_nxt.pinOe[GCP_PIN_WAKE] = 1'h1;
         state_nxt.pinOut[GCP_PIN_WAKE] = radioHostWakeupOut;
      end
      // coexistence function of pins one to four
      unique case (coexMode)
         GCP_MODE_GPIO: begin
            // pins one to four stay general purpose
         end
         GCP_MODE_TWO: begin
            // serial link muxed onto pins one and two, UART framed
            state_nxt.pinOe[GCP_PIN_1] = 1'h1;
            state_nxt.pinOut[GCP_PIN_1] = coexSerialOut;
            state_nxt.pinOe[GCP_PIN_2] = 1'h0;
            state_nxt.pinOut[GCP_PIN_2] = 1'h0;
            state_nxt.serialIn = syncIn[GCP_PIN_2];
         end
         GCP_MODE_THREE: begin
            // priority on pin two, peer activity on three and four
            state_nxt.pinOe[GCP_PIN_2] = 1'h1;
            state_nxt.pinOut[GCP_PIN_2] = prioAny;
            state_nxt.pinOe[GCP_PIN_3] = 1'h0;
            state_nxt.pinOe[GCP_PIN_4] = 1'h0;
            state_nxt.pinOut[GCP_PIN_3] = 1'h0;
            state_nxt.pinOut[GCP_PIN_4] = 1'h0;
            state_nxt.rxAct = syncIn[GCP_PIN_3];
            state_nxt.txAct = syncIn[GCP_PIN_4];
         end
         GCP_MODE_FOUR: begin
            // priority on pin one, frame sync on two, activity on three and four
            state_nxt.pinOe[GCP_PIN_1] = 1'h1;
            state_nxt.pinOut[GCP_PIN_1] = prioAny;
            state_nxt.pinOe[GCP_PIN_2] = 1'h0;
            state_nxt.pinOut[GCP_PIN_2] = 1'h0;
            state_nxt.frameSync = syncIn[GCP_PIN_2];
            state_nxt.pinOe[GCP_PIN_3] = 1'h0;
            state_nxt.pinOe[GCP_PIN_4] = 1'h0;
            state_nxt.pinOut[GCP_PIN_3] = 1'h0;
            state_nxt.pinOut[GCP_PIN_4] = 1'h0;
            state_nxt.rxAct = syncIn[GCP_PIN_3];
            state_nxt.txAct = syncIn[GCP_PIN_4];
         end
      endcase
   end

   // register state; reset leaves every pin undriven and unpulled
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r.pinOut <= GCP_RST_PINS;
         state_r.pinOe <= GCP_RST_PINS;
         state_r.pullUpEn <= GCP_RST_PINS;
         state_r.pullDownEn <= GCP_RST_PINS;
         state_r.serialIn <= GCP_SERIAL_IDLE;
         state_r.rxAct <= 1'h0;
         state_r.txAct <= 1'h0;
         state_r.frameSync <= 1'h0;
         state_r.prio <= 1'h0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // outputs straight from flops
   assign gpioO = state_r.pinOut;
   assign gpioOe = state_r.pinOe;
   assign pullUpEn = state_r.pullUpEn;
   assign pullDownEn = state_r.pullDownEn;
   assign pinRead = syncIn;
   assign coexSerialIn = state_r.serialIn;
   assign peerReceiveActive = state_r.rxAct;
   assign peerTransmitActive = state_r.txAct;
   assign peerFrameSync = state_r.frameSync;
   assign priorityOut = state_r.prio;

   // pins released during and right after reset
   property p_resetHiZ;
      @(posedge mclk) rst |=> (gpioOe == 5'h00) && (pullUpEn == 5'h00) && (pullDownEn == 5'h00);
   endproperty
   a_resetHiZ: assert property (p_resetHiZ) else $error("pin driven after reset");

   // general mode follows the direction input one cycle later
   property p_dirFollows;
      @(posedge mclk) disable iff (rst)
         (coexMode == GCP_MODE_GPIO && !wakeSel) |=> gpioOe == $past(pinDir);
   endproperty
   a_dirFollows: assert property (p_dirFollows) else $error("direction not applied");

   // pull selection: up and down never together, follow request
   property p_pull;
      @(posedge mclk) disable iff (rst)
         1'h1 |=> (pullUpEn == $past(pullEn & pullSelUp)) && ((pullUpEn & pullDownEn) == 5'h00);
   endproperty
   a_pull: assert property (p_pull) else $error("pull setting wrong");

   // wakeup output on pin zero
   property p_wake;
      @(posedge mclk) disable iff (rst)
         wakeSel |=> gpioOe[0] && (gpioO[0] == $past(radioHostWakeupOut));
   endproperty
   a_wake: assert property (p_wake) else $error("wakeup not on pin zero");

   // two-wire serial out on pin one, in from pin two
   property p_two;
      @(posedge mclk) disable iff (rst)
         coexMode == GCP_MODE_TWO |=> gpioOe[1] && !gpioOe[2] && (gpioO[1] == $past(coexSerialOut))
            && (coexSerialIn == $past(syncIn[2]));
   endproperty
   a_two: assert property (p_two) else $error("two-wire mapping wrong");

   // three-wire priority on pin two, peer inputs on three and four
   property p_three;
      @(posedge mclk) disable iff (rst)
         coexMode == GCP_MODE_THREE |=> gpioOe[2] && !gpioOe[3] && !gpioOe[4]
            && (gpioO[2] == $past(prioAny)) && (peerTransmitActive == $past(syncIn[4]));
   endproperty
   a_three: assert property (p_three) else $error("three-wire mapping wrong");

   // four-wire priority on pin one is the masked OR
   property p_four;
      @(posedge mclk) disable iff (rst)
         coexMode == GCP_MODE_FOUR |=> gpioOe[1] && !gpioOe[2]
            && (gpioO[1] == $past(|(prioSrc & prioMask))) && (peerReceiveActive == $past(syncIn[3]));
   endproperty
   a_four: assert property (p_four) else $error("four-wire mapping wrong");

   // frame sync quiet outside four-wire
   property p_frameSync;
      @(posedge mclk) disable iff (rst)
         coexMode != GCP_MODE_FOUR |=> !peerFrameSync;
   endproperty
   a_frameSync: assert property (p_frameSync) else $error("frame sync outside four-wire");

   // pin level reaches read-back after two synchroniser stages
   property p_readBack;
      @(posedge mclk) disable iff (rst)
         !$past(rst, 2) && !$past(rst) |-> pinRead == $past(gpioI, 2);
   endproperty
   a_readBack: assert property (p_readBack) else $error("read-back latency wrong");

   // serial input rests idle outside two-wire
   property p_serialIdle;
      @(posedge mclk) disable iff (rst)
         coexMode != GCP_MODE_TWO |=> coexSerialIn;
   endproperty
   a_serialIdle: assert property (p_serialIdle) else $error("serial input not idle");

   // peer activity reads low where no mode claims pins three and four
   property p_peerIdle;
      @(posedge mclk) disable iff (rst)
         (coexMode == GCP_MODE_GPIO || coexMode == GCP_MODE_TWO) |=> !peerReceiveActive && !peerTransmitActive;
   endproperty
   a_peerIdle: assert property (p_peerIdle) else $error("peer activity outside three or four wire");

   // modes never claim pin zero; without wakeup it follows software
   property p_pinZero;
      @(posedge mclk) disable iff (rst)
         !wakeSel |=> (gpioOe[0] == $past(pinDir[0])) && (gpioO[0] == $past(pinWrite[0]));
   endproperty
   a_pinZero: assert property (p_pinZero) else $error("pin zero not under software");

   // priority flop holds the masked OR of the sources
   property p_prio;
      @(posedge mclk) disable iff (rst)
         1'h1 |=> priorityOut == $past(|(prioSrc & prioMask));
   endproperty
   a_prio: assert property (p_prio) else $error("priority not the masked OR");

   // main scenarios
   c_two: cover property (@(posedge mclk) disable iff (rst) coexMode == GCP_MODE_TWO ##1 coexSerialIn == 1'h0);
   c_three: cover property (@(posedge mclk) disable iff (rst) coexMode == GCP_MODE_THREE ##1 gpioO[2]);
   c_four: cover property (@(posedge mclk) disable iff (rst) coexMode == GCP_MODE_FOUR ##1 peerFrameSync);
   c_wake: cover property (@(posedge mclk) disable iff (rst) wakeSel ##1 gpioO[0]);

endmodule

/* File: hdl/gcp_pkg.sv */
// constants, types and reset values of the coexistence-capable pin block
// assumes one 100 MHz clock and a synchronous active-high reset in every user
package gcp_pkg;

   // pin count and pin indices
   localparam int GCP_NUM_PINS = 5;
   localparam int GCP_PIN_WAKE = 0;
   localparam int GCP_PIN_1 = 1;
   localparam int GCP_PIN_2 = 2;
   localparam int GCP_PIN_3 = 3;
   localparam int GCP_PIN_4 = 4;

   // number of internal priority sources
   localparam int GCP_NUM_PRIO = 4;

   // reset values
   localparam logic [4:0] GCP_RST_PINS = 5'h00;
   localparam logic GCP_SERIAL_IDLE = 1'h1;

   // pin function selection
   typedef enum logic [1:0] {
      GCP_MODE_GPIO = 2'b00,
      GCP_MODE_TWO = 2'b01,
      GCP_MODE_THREE = 2'b10,
      GCP_MODE_FOUR = 2'b11
   } gcp_mode_t;

   // registered state of the pin block
   typedef struct packed {
      logic [4:0] pinOut;
      logic [4:0] pinOe;
      logic [4:0] pullUpEn;
      logic [4:0] pullDownEn;
      logic serialIn;
      logic rxAct;
      logic txAct;
      logic frameSync;
      logic prio;
   } gcp_state_t;

endpackage

/* File: hdl/gcp_sync.sv */
// two-flop synchroniser for the pin input levels
// assumes inputs come straight from pads, asynchronous to mclk
`timescale 1ns/1ps
module gcp_sync
   import gcp_pkg::*;
#(
   parameter int WIDTH = 5
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);

   // first and second stage
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } gcp_sync_t;

   gcp_sync_t state_r; // stage registers
   gcp_sync_t state_nxt; // next stage values

   // shift the pin levels through both stages
   always_comb begin
      state_nxt = state_r;
      state_nxt.meta = asyncIn;
      state_nxt.stable = state_r.meta;
   end

   // register the stages
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign syncOut = state_r.stable;

endmodule

/* File: tb/gcp_peer_radio.sv */
// model of the co-located radio on the far side of pins 2..4
// assumes the bench sets its line values just after a falling edge
`timescale 1ns/1ps
module gcp_peer_radio
   import gcp_pkg::*;
(
   input wire logic mclk,
   input wire gcp_mode_t coexMode,
   input wire logic [4:0] gpioO,
   input wire logic [4:0] gpioOe,
   input wire logic [4:0] pullUpEn,
   input wire logic [4:0] pullDownEn,
   output logic [4:0] gpioI
);
   logic serLine = 1'h1; // uart line toward device, idle high
   logic rxAct = 1'h0; // receive-active indication
   logic txAct = 1'h0; // transmit-active indication
   logic frameSync = 1'h0; // frame sync level
   logic flt = 1'h0; // level seen on an undriven pin
   logic [4:0] peerOe;
   logic [4:0] peerVal;
   // undriven, unpulled pins change every cycle
   always @(posedge mclk) begin
      flt <= ~flt;
   end
   // pins the peer drives in each mode
   always_comb begin
      peerOe = 5'h00;
      peerOe[2] = coexMode == GCP_MODE_TWO || coexMode == GCP_MODE_FOUR;
      peerOe[4:3] = {2{coexMode[1]}};
      peerVal = {txAct, rxAct, coexMode == GCP_MODE_FOUR ? frameSync : serLine, 2'h0};
   end
   // wire level from both parties and the pulls
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         if (gpioOe[i])
            gpioI[i] = gpioO[i];
         else if (peerOe[i])
            gpioI[i] = peerVal[i];
         else if (pullUpEn[i] || pullDownEn[i])
            gpioI[i] = pullUpEn[i];
         else
            gpioI[i] = flt;
      end
   end
endmodule

/* File: tb/tb_gcp_pins.sv */
// self-checking bench for the coexistence pin block
// assumes the peer model resolves the pad levels
`timescale 1ns/1ps
module tb_gcp_pins
   import gcp_pkg::*;
;
   logic mclk, rst, wakeSel, hostWake, serOut, serIn, pRx, pTx, pSync, prio, pb, eP;
   logic [4:0] pinDir, pinWrite, pullEn, pullSelUp, gpioI, gpioO, gpioOe;
   logic [4:0] pullUpEn, pullDownEn, pinRead, eOe, eO, eW, pv, rd, ePeer;
   logic [3:0] prioSrc, prioMask;
   logic [9:0] frame;
   gcp_mode_t coexMode;
   int num_errors = 0;
   int check_count = 0;
   gcp_pins u_gcp_pins (.mclk(mclk), .rst(rst), .pinDir(pinDir), .pinWrite(pinWrite),
      .pullEn(pullEn), .pullSelUp(pullSelUp), .wakeSel(wakeSel), .coexMode(coexMode),
      .radioHostWakeupOut(hostWake), .coexSerialOut(serOut), .prioSrc(prioSrc),
      .prioMask(prioMask), .gpioI(gpioI), .gpioO(gpioO), .gpioOe(gpioOe), .pullUpEn(pullUpEn),
      .pullDownEn(pullDownEn), .pinRead(pinRead), .coexSerialIn(serIn), .peerReceiveActive(pRx),
      .peerTransmitActive(pTx), .peerFrameSync(pSync), .priorityOut(prio));
   gcp_peer_radio u_gcp_peer_radio (.mclk(mclk), .coexMode(coexMode), .gpioO(gpioO),
      .gpioOe(gpioOe), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn), .gpioI(gpioI));
   // compare a vector result
   task automatic chk(input string name, input logic [4:0] exp, input logic [4:0] got);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   // verdict and end of run
   task automatic stop_test;
      if (num_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // let inputs reach every output
   task automatic settle;
      repeat (5) @(negedge mclk);
   endtask
   // write one pin configuration at a falling edge, then let it settle
   task automatic write_cfg(input gcp_mode_t mode, input logic [4:0] dir, input logic [4:0] wr,
      input logic [4:0] selUp, input logic wake, input logic [3:0] mask);
      coexMode = mode;
      pinDir = dir;
      pinWrite = wr;
      pullSelUp = selUp;
      wakeSel = wake;
      prioMask = mask;
      settle;
   endtask
   // read back the synchronised pin levels
   task automatic read_pins(output logic [4:0] lvl);
      lvl = pinRead;
   endtask
   // clock
   initial begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   // hang guard
   initial begin
      #20000;
      num_errors++;
      stop_test;
   end
   // main sequence
   initial begin
      rst = 1'h1;
      pinDir = 5'h1F;
      pinWrite = 5'h1F;
      pullEn = 5'h1F;
      pullSelUp = 5'h0F;
      wakeSel = 1'h1;
      coexMode = GCP_MODE_FOUR;
      hostWake = 1'h1;
      serOut = 1'h1;
      prioSrc = 4'hF;
      prioMask = 4'hF;
      repeat (10) @(negedge mclk);
      chk("oe", 5'h00, gpioOe);
      chk("pulls", 5'h00, pullUpEn | pullDownEn);
      rst = 1'h0;
      // every mode, two data patterns each; wake level differs from pinWrite in modes 0 and 2
      for (int m = 0; m < 4; m++) begin
         for (int p = 0; p < 2; p++) begin
            pb = p[0];
            hostWake = m[0];
            serOut = pb;
            prioSrc = 4'hA;
            u_gcp_peer_radio.serLine = ~pb;
            u_gcp_peer_radio.rxAct = pb;
            u_gcp_peer_radio.txAct = ~pb;
            u_gcp_peer_radio.frameSync = pb;
            write_cfg(gcp_mode_t'(m[1:0]), pb ? 5'h1F : 5'h1E, pb ? 5'h15 : 5'h0A,
               pb ? 5'h0F : 5'h12, pb, pb ? 4'h6 : 4'h5);
            eP = pb;
            eOe = pinDir;
            eO = pinWrite;
            eOe[0] = eOe[0] | pb;
            eO[0] = pb ? hostWake : eO[0];
            case (m)
               1: begin
                  eOe[2:1] = 2'h1;
                  eO[1] = serOut;
               end
               2: begin
                  eOe[4:2] = 3'h1;
                  eO[2] = eP;
               end
               3: begin
                  eOe[4:1] = 4'h1;
                  eO[1] = eP;
               end
               default: begin
               end
            endcase
            pv = {~pb, pb, m == 3 ? pb : ~pb, pullSelUp[1:0]};
            eW = (eO & eOe) | (pv & ~eOe);
            ePeer = {m == 1 ? ~pb : 1'h1, m > 1 && pb, m > 1 && !pb, m == 3 && pb, eP};
            read_pins(rd);
            chk("oe", eOe, gpioOe);
            chk("out", eO & eOe, gpioO & gpioOe);
            chk("read", eW, rd);
            chk("pullup", pullSelUp, pullUpEn);
            chk("pulldown", ~pullSelUp, pullDownEn);
            chk("peer", ePeer, {serIn, pRx, pTx, pSync, prio});
         end
      end
      // one character each way over the serial link
      coexMode = GCP_MODE_TWO;
      frame = {1'h1, 8'hA5, 1'h0};
      for (int b = 0; b < 10; b++) begin
         u_gcp_peer_radio.serLine = frame[b];
         serOut = ~frame[b];
         settle;
         chk("serin", {4'h0, frame[b]}, {4'h0, serIn});
         chk("serout", {3'h0, ~frame[b], 1'h0}, gpioO & 5'h02);
      end
      // reset again in mid-run, then release it and see the two-wire setup come back
      rst = 1'h1;
      settle;
      chk("oe", 5'h00, gpioOe);
      chk("pulls", 5'h00, pullUpEn | pullDownEn);
      rst = 1'h0;
      settle;
      chk("oe", 5'h1B, gpioOe);
      stop_test;
   end
endmodule
